// >>> verilog/pwmfps_regs.vh
// Purpose: constants for the pwm fault protection sequencer
// Assumes: clk_sys at 100 MHz; fault time base ticks once per millisecond
// Notes:   definitions only
`ifndef PWMFPS_REGS_VH
`define PWMFPS_REGS_VH

`define PWMFPS_CLK_MHZ            100
// latch input confirmation count in switching cycles
`define PWMFPS_LATCH_COUNT        4
// blanking after drive turn-off, in ns, and its cycle count
`define PWMFPS_BLANK_NS           1000
`define PWMFPS_BLANK_CYC          ((`PWMFPS_BLANK_NS * `PWMFPS_CLK_MHZ + 999) / 1000)
// rail overvoltage confirm delay, in us, and its cycle count
`define PWMFPS_RAIL_OV_US         20
`define PWMFPS_RAIL_OV_CYC        (`PWMFPS_RAIL_OV_US * `PWMFPS_CLK_MHZ)
// microsecond tick divider
`define PWMFPS_US_CYC             `PWMFPS_CLK_MHZ
// fault times in milliseconds
`define PWMFPS_OVERLOAD_MS        500
`define PWMFPS_FAULT_SHORTED_MS   50
`define PWMFPS_FAULT_OPEN_MS      1000
// soft-start time in milliseconds
`define PWMFPS_SOFT_START_MS      4
// oscillator periods in ns
`define PWMFPS_NOM_PERIOD_NS      15385
`define PWMFPS_MAX_PERIOD_NS      7693
`define PWMFPS_MIN_PERIOD_NS      38462
// jitter swing in ns around the period
`define PWMFPS_JITTER_NS          769
// frequency modes
`define PWMFPS_MODE_NOMINAL       3'h0
`define PWMFPS_MODE_EXCURSION     3'h1
`define PWMFPS_MODE_FOLDBACK      3'h2
`define PWMFPS_MODE_FREEZE        3'h3
`define PWMFPS_MODE_SKIP          3'h4

`endif

// >>> verilog/pwmfps_persist.v
// Purpose: persistence filter, output high after input held N counts
// Assumes: cnt_en qualifies which clocks count; input synchronous
// Notes:   a low input clears the count
`timescale 1ns/1ps
module pwmfps_persist #(
  parameter WIDTH = 12,
  parameter [WIDTH-1:0] LIMIT = 12'h004
) (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire level_in,
  input  wire cnt_en,
  output reg  hit_q
);
  reg [WIDTH-1:0] cnt_q;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {WIDTH{1'b0}};
      hit_q <= 1'b0;
    end else if (!level_in) begin
      cnt_q <= {WIDTH{1'b0}};
      hit_q <= 1'b0;
    end else if (cnt_en && cnt_q < LIMIT) begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      hit_q <= (cnt_q + {{(WIDTH-1){1'b0}}, 1'b1}) >= LIMIT;
    end
  end
endmodule // pwmfps_persist

// >>> verilog/pwmfps_top.v
// Purpose: fault, latch, brown-out, hiccup and oscillator mode sequencing
// Assumes: comparator inputs already synchronous to clk_sys
// Notes:   drive_en gates the gate driver; osc_tick is the switching clock
`timescale 1ns/1ps
`include "pwmfps_regs.vh"
module pwmfps_top #(
  parameter [19:0] OVERLOAD_MS   = `PWMFPS_OVERLOAD_MS,
  parameter        SHORT_LATCH   = 0,
  parameter [19:0] US_PER_MS     = 20'h003E8,
  parameter [7:0]  CYC_PER_US    = `PWMFPS_US_CYC
) (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       latch_input_high,
  input  wire       rail_overvoltage_level,
  input  wire       latch_hold_current,
  input  wire       undervolt_ok,
  input  wire       supply_turn_on_event,
  input  wire       supply_min_event,
  input  wire       peak_limit_hit,
  input  wire       overload_feedback_level,
  input  wire       short_circuit_feedback_level,
  input  wire       foldback_feedback_level,
  input  wire       fold_end_feedback_level,
  input  wire       freeze_feedback_level,
  input  wire       skip_feedback_level,
  input  wire       timer_pin_shorted,
  input  wire       timer_pin_open,
  input  wire       drive_off_edge,
  output reg        drive_en_q,
  output reg        latched_q,
  output reg        error_flag_q,
  output reg        soft_start_q,
  output reg        hiccup_q,
  output reg        general_reset_q,
  output reg        setpoint_freeze_q,
  output reg  [2:0] freq_mode_q,
  output reg        osc_tick_q
);
  localparam [2:0] ST_WAIT_ON  = 3'h0;
  localparam [2:0] ST_SOFT     = 3'h1;
  localparam [2:0] ST_RUN      = 3'h2;
  localparam [2:0] ST_HICCUP   = 3'h3;
  localparam [2:0] ST_SHORT_LO = 3'h4;

  localparam [15:0] BLANK_CYC   = `PWMFPS_BLANK_CYC;
  localparam [11:0] RAIL_CYC    = `PWMFPS_RAIL_OV_CYC;
  localparam [15:0] NOM_CYC     = (`PWMFPS_NOM_PERIOD_NS * `PWMFPS_CLK_MHZ) / 1000;
  localparam [15:0] MAX_CYC     = (`PWMFPS_MAX_PERIOD_NS * `PWMFPS_CLK_MHZ) / 1000;
  localparam [15:0] MIN_CYC     = (`PWMFPS_MIN_PERIOD_NS * `PWMFPS_CLK_MHZ) / 1000;
  localparam [15:0] JIT_CYC     = (`PWMFPS_JITTER_NS * `PWMFPS_CLK_MHZ) / 1000;
  localparam [19:0] SS_MS       = `PWMFPS_SOFT_START_MS;
  localparam [19:0] SHORTED_MS  = `PWMFPS_FAULT_SHORTED_MS;
  localparam [19:0] OPEN_MS     = `PWMFPS_FAULT_OPEN_MS;

  reg  [2:0]  state_q;
  reg  [15:0] blank_cnt_q;
  reg  [7:0]  us_cnt_q;
  reg         us_tick_q;
  reg  [19:0] ms_us_q;
  reg         ms_tick_q;
  reg  [19:0] fault_ms_q;
  reg  [19:0] ss_ms_q;
  reg         hic_div_q;
  reg         bo_prev_q;
  reg  [15:0] osc_cnt_q;
  reg  [15:0] period_q;
  reg  [15:0] jit_q;
  reg         jit_up_q;
  reg  [19:0] fault_limit;
  wire        latch_cfm;
  wire        rail_cfm;
  wire        latch_qual;
  wire        latch_blank;
  wire        bo_rise;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blank_cnt_q <= 16'h0000;
    end else if (drive_off_edge) begin
      blank_cnt_q <= BLANK_CYC;
    end else if (blank_cnt_q != 16'h0000) begin
      blank_cnt_q <= blank_cnt_q - 16'h0001;
    end
  end
  assign latch_blank = (blank_cnt_q != 16'h0000) || drive_off_edge;
  assign latch_qual  = latch_input_high || latch_blank;

  pwmfps_persist #(.WIDTH(12), .LIMIT(12'h004)) u_latch_cfm (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .level_in (latch_qual),
    .cnt_en   (osc_tick_q && !latch_blank),
    .hit_q    (latch_cfm)
  );
  pwmfps_persist #(.WIDTH(12), .LIMIT(RAIL_CYC)) u_rail_cfm (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .level_in (rail_overvoltage_level),
    .cnt_en   (1'b1),
    .hit_q    (rail_cfm)
  );

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latched_q <= 1'b0;
    end else if (latch_cfm || rail_cfm) begin
      latched_q <= 1'b1;
    end else if (!latch_hold_current) begin
      latched_q <= 1'b0;
    end
  end

  // time base: microsecond then millisecond ticks
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      us_cnt_q  <= 8'h00;
      us_tick_q <= 1'b0;
      ms_us_q   <= 20'h00000;
      ms_tick_q <= 1'b0;
    end else begin
      us_tick_q <= (us_cnt_q == CYC_PER_US - 8'h01);
      us_cnt_q  <= (us_cnt_q == CYC_PER_US - 8'h01) ? 8'h00 : us_cnt_q + 8'h01;
      ms_tick_q <= 1'b0;
      if (us_tick_q) begin
        if (ms_us_q == US_PER_MS - 20'h00001) begin
          ms_us_q   <= 20'h00000;
          ms_tick_q <= 1'b1;
        end else begin
          ms_us_q <= ms_us_q + 20'h00001;
        end
      end
    end
  end

  always @* begin
    if (timer_pin_shorted) begin
      fault_limit = SHORTED_MS;
    end else if (timer_pin_open) begin
      fault_limit = OPEN_MS;
    end else begin
      fault_limit = OVERLOAD_MS;
    end
    if (short_circuit_feedback_level) begin
      fault_limit = {2'b00, fault_limit[19:2]};
    end
  end

  // brown-out recovery edge
  assign bo_rise = undervolt_ok && !bo_prev_q;

  // main sequencer
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q         <= ST_WAIT_ON;
      fault_ms_q      <= 20'h00000;
      ss_ms_q         <= 20'h00000;
      hic_div_q       <= 1'b0;
      bo_prev_q       <= 1'b0;
      error_flag_q    <= 1'b0;
      general_reset_q <= 1'b0;
    end else begin
      bo_prev_q       <= undervolt_ok;
      general_reset_q <= 1'b0;
      error_flag_q    <= peak_limit_hit && (state_q == ST_SOFT || state_q == ST_RUN);
      if (!undervolt_ok) begin
        state_q    <= ST_WAIT_ON;
        fault_ms_q <= 20'h00000;
      end else if (bo_rise) begin
        general_reset_q <= 1'b1;
        state_q         <= ST_WAIT_ON;
        hic_div_q       <= 1'b0;
        fault_ms_q      <= 20'h00000;
      end else begin
        case (state_q)
          ST_WAIT_ON: begin
            if (supply_turn_on_event && !latched_q) begin
              state_q <= ST_SOFT;
              ss_ms_q <= 20'h00000;
            end
          end
          ST_SOFT, ST_RUN: begin
            if (state_q == ST_SOFT && ms_tick_q) begin
              if (ss_ms_q == SS_MS - 20'h00001) begin
                state_q <= ST_RUN;
              end
              ss_ms_q <= ss_ms_q + 20'h00001;
            end
            if (peak_limit_hit && (overload_feedback_level || short_circuit_feedback_level)) begin
              if (ms_tick_q) begin
                fault_ms_q <= fault_ms_q + 20'h00001;
              end
              if (fault_ms_q >= fault_limit) begin
                fault_ms_q <= 20'h00000;
                if (SHORT_LATCH != 0 && short_circuit_feedback_level) begin
                  state_q <= ST_SHORT_LO;
                end else begin
                  state_q   <= ST_HICCUP;
                  hic_div_q <= 1'b1;
                end
              end
            end else begin
              fault_ms_q <= 20'h00000;
            end
          end
          ST_HICCUP: begin
            if (supply_turn_on_event) begin
              if (hic_div_q) begin
                state_q <= ST_SOFT;
                ss_ms_q <= 20'h00000;
              end
            end else if (supply_min_event) begin
              hic_div_q <= ~hic_div_q;
            end
          end
          ST_SHORT_LO: begin
            state_q <= ST_SHORT_LO;
          end
          default: begin
            state_q <= ST_WAIT_ON;
          end
        endcase
      end
    end
  end

  // drive gating and status
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive_en_q   <= 1'b0;
      soft_start_q <= 1'b0;
      hiccup_q     <= 1'b0;
    end else begin
      drive_en_q   <= (state_q == ST_SOFT || state_q == ST_RUN) && !latched_q &&
                      !latch_cfm && !rail_cfm && undervolt_ok &&
                      (freq_mode_q != `PWMFPS_MODE_SKIP);
      soft_start_q <= (state_q == ST_SOFT);
      hiccup_q     <= (state_q == ST_HICCUP);
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      freq_mode_q       <= `PWMFPS_MODE_NOMINAL;
      setpoint_freeze_q <= 1'b0;
      period_q          <= NOM_CYC;
    end else begin
      setpoint_freeze_q <= !freeze_feedback_level;
      if (!skip_feedback_level) begin
        freq_mode_q <= `PWMFPS_MODE_SKIP;
        period_q    <= MIN_CYC;
      end else if (!freeze_feedback_level) begin
        freq_mode_q <= `PWMFPS_MODE_FREEZE;
        period_q    <= MIN_CYC;
      end else if (!fold_end_feedback_level) begin
        freq_mode_q <= `PWMFPS_MODE_FOLDBACK;
        period_q    <= MIN_CYC;
      end else if (!foldback_feedback_level) begin
        freq_mode_q <= `PWMFPS_MODE_FOLDBACK;
        period_q    <= NOM_CYC + ((MIN_CYC - NOM_CYC) >> 1);
      end else if (peak_limit_hit && state_q == ST_RUN) begin
        freq_mode_q <= `PWMFPS_MODE_EXCURSION;
        period_q    <= short_circuit_feedback_level ? MAX_CYC
                       : NOM_CYC - ((NOM_CYC - MAX_CYC) >> 1);
      end else begin
        freq_mode_q <= `PWMFPS_MODE_NOMINAL;
        period_q    <= NOM_CYC;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_q  <= 16'h0000;
      osc_tick_q <= 1'b0;
      jit_q      <= 16'h0000;
      jit_up_q   <= 1'b1;
    end else begin
      osc_tick_q <= 1'b0;
      if (osc_cnt_q >= period_q + jit_q - JIT_CYC) begin
        osc_cnt_q  <= 16'h0000;
        osc_tick_q <= 1'b1;
        if (freq_mode_q == `PWMFPS_MODE_NOMINAL || freq_mode_q == `PWMFPS_MODE_FOLDBACK) begin
          if (jit_up_q) begin
            jit_q    <= jit_q + 16'h0001;
            jit_up_q <= (jit_q + 16'h0001) < (JIT_CYC << 1);
          end else begin
            jit_q    <= jit_q - 16'h0001;
            jit_up_q <= (jit_q == 16'h0001);
          end
        end else begin
          jit_q <= JIT_CYC;
        end
      end else begin
        osc_cnt_q <= osc_cnt_q + 16'h0001;
      end
    end
  end
endmodule // pwmfps_top

// >>> test/pwmfps_checker.sv
// Purpose: port-level assertions for pwmfps_top
// Assumes: one clock domain, async active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module pwmfps_checker (
  input wire       clk_sys,
  input wire       rst_n,
  input wire       latch_input_high,
  input wire       rail_overvoltage_level,
  input wire       latch_hold_current,
  input wire       undervolt_ok,
  input wire       peak_limit_hit,
  input wire       drive_en_q,
  input wire       latched_q,
  input wire       error_flag_q,
  input wire       soft_start_q,
  input wire       general_reset_q,
  input wire       setpoint_freeze_q,
  input wire [2:0] freq_mode_q,
  input wire       osc_tick_q
);
  reg [11:0] ov_cnt_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // consecutive rail overvoltage cycles
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ov_cnt_q <= 12'h000;
    else if (!rail_overvoltage_level) ov_cnt_q <= 12'h000;
    else if (ov_cnt_q != 12'hFFF) ov_cnt_q <= ov_cnt_q + 12'h001;
  end
  sequence peak_seen; peak_limit_hit && drive_en_q; endsequence
  sequence soft_begin; $rose(soft_start_q); endsequence
  latch_drive_a: assert property (latched_q |-> !drive_en_q)
    else $error("drive active while latched");
  latch_keep_a: assert property (latched_q && latch_hold_current |=> latched_q)
    else $error("latch lost while hold current present");
  latch_cause_a: assert property ($rose(latched_q) |->
    $past(latch_input_high, 2) || ov_cnt_q >= 12'h7CE)
    else $error("latch fired without a cause");
  rail_late_a: assert property (ov_cnt_q >= 12'h7DA |-> latched_q)
    else $error("rail overvoltage not latched");
  bo_stop_a: assert property (!undervolt_ok [*3] |-> !drive_en_q)
    else $error("drive active in brown-out");
  gr_cause_a: assert property ($rose(undervolt_ok) |-> ##[1:3] general_reset_q)
    else $error("no general reset on recovery");
  gr_pulse_a: assert property (general_reset_q |=> !general_reset_q)
    else $error("general reset longer than one cycle");
  err_flag_a: assert property (peak_seen |-> ##[0:2] error_flag_q)
    else $error("error flag missing at peak limit");
  soft_drive_a: assert property (soft_begin |-> ##[0:1] drive_en_q)
    else $error("soft-start without drive");
  tick_pulse_a: assert property (osc_tick_q |=> !osc_tick_q)
    else $error("oscillator tick longer than one cycle");
  freeze_set_a: assert property ((freq_mode_q == 3'h3) [*2] |-> setpoint_freeze_q)
    else $error("setpoint not frozen in freeze mode");
endmodule // pwmfps_checker

// >>> test/pwmfps_power_model.sv
// Purpose: gate driver side of the power stage
// Assumes: on-time fixed in clocks after each switching tick
// Notes:   pulses drive_off_edge at every turn-off
`timescale 1ns/1ps
module pwmfps_power_model #(
  parameter ON_CYC = 600
) (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire drive_en_q,
  input  wire osc_tick_q,
  output reg  drive_off_edge
);
  integer cnt;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      drive_off_edge <= 1'b0;
    end else begin
      drive_off_edge <= (cnt == 1);
      if (osc_tick_q && drive_en_q) cnt <= ON_CYC;
      else if (!drive_en_q && cnt > 1) cnt <= 1;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule // pwmfps_power_model

// >>> test/tb_pwm_fault_protection_sequencer.sv
// Purpose: self-checking bench for pwmfps_top
// Assumes: 1 ms shortened to 20 clocks
// Notes:   partner model makes turn-off edges
`timescale 1ns/1ps
`include "pwmfps_regs.vh"
module tb_pwm_fault_protection_sequencer;
  reg clk_sys = 0, rst_n = 0, latch_input_high = 0, rail_overvoltage_level = 0;
  reg latch_hold_current = 1, undervolt_ok = 0, supply_turn_on_event = 0;
  reg supply_min_event = 0, peak_limit_hit = 0, overload_feedback_level = 0;
  reg short_circuit_feedback_level = 0, foldback_feedback_level = 1;
  reg fold_end_feedback_level = 1, freeze_feedback_level = 1, skip_feedback_level = 1;
  reg timer_pin_shorted = 0, timer_pin_open = 0, ok;
  wire drive_off_edge, drive_en_q, latched_q, error_flag_q, soft_start_q, hiccup_q;
  wire general_reset_q, setpoint_freeze_q, osc_tick_q;
  wire [2:0] freq_mode_q;
  integer n_errors = 0, comparisons = 0, cycles = 0, i, k, c, e, n;
  reg [31:0] seed = 32'd59119;
  wire lo_drive_en_q;
  pwmfps_top #(.OVERLOAD_MS(20'h00028), .US_PER_MS(20'h00002), .CYC_PER_US(8'h0A)) i_dut (
    .clk_sys, .rst_n, .latch_input_high, .rail_overvoltage_level, .latch_hold_current,
    .undervolt_ok, .supply_turn_on_event, .supply_min_event, .peak_limit_hit,
    .overload_feedback_level, .short_circuit_feedback_level, .foldback_feedback_level,
    .fold_end_feedback_level, .freeze_feedback_level, .skip_feedback_level,
    .timer_pin_shorted, .timer_pin_open, .drive_off_edge, .drive_en_q, .latched_q,
    .error_flag_q, .soft_start_q, .hiccup_q, .general_reset_q, .setpoint_freeze_q,
    .freq_mode_q, .osc_tick_q);
  pwmfps_power_model i_pm (.clk_sys, .rst_n, .drive_en_q, .osc_tick_q, .drive_off_edge);
  // latch-off build option on short-circuit
  pwmfps_top #(.OVERLOAD_MS(20'h00028), .SHORT_LATCH(1), .US_PER_MS(20'h00002),
    .CYC_PER_US(8'h0A)) i_dut_lo (
    .clk_sys, .rst_n, .latch_input_high, .rail_overvoltage_level, .latch_hold_current,
    .undervolt_ok, .supply_turn_on_event, .supply_min_event, .peak_limit_hit,
    .overload_feedback_level, .short_circuit_feedback_level, .foldback_feedback_level,
    .fold_end_feedback_level, .freeze_feedback_level, .skip_feedback_level,
    .timer_pin_shorted, .timer_pin_open, .drive_off_edge, .drive_en_q(lo_drive_en_q),
    .latched_q(), .error_flag_q(), .soft_start_q(), .hiccup_q(), .general_reset_q(),
    .setpoint_freeze_q(), .freq_mode_q(), .osc_tick_q());
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  function [31:0] rnd(input integer d);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  function sel(input integer s);
    case (s)
      0: sel = latched_q;
      1: sel = hiccup_q;
      2: sel = soft_start_q;
      3: sel = general_reset_q;
      4: sel = osc_tick_q;
      5: sel = !latched_q;
      default: sel = !soft_start_q;
    endcase
  endfunction
  task cyc(input integer m);
    begin
      repeat (m) @(posedge clk_sys);
      #1;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [31:0] tol);
    begin
      comparisons = comparisons + 1;
      ok = (got + tol >= exp) && (got <= exp + tol);
      if (ok !== 1'b1) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer s, input integer lim);
    begin
      c = 0;
      while (c < lim && sel(s) !== 1'b1) begin
        cyc(1);
        c = c + 1;
      end
    end
  endtask
  task ev(input integer s);
    begin
      @(posedge clk_sys);
      if (s) supply_min_event <= 1'b1;
      else supply_turn_on_event <= 1'b1;
      @(posedge clk_sys);
      supply_min_event <= 1'b0;
      supply_turn_on_event <= 1'b0;
      #1;
    end
  endtask
  task start;
    begin
      @(posedge clk_sys);
      rst_n <= 1'b0;
      undervolt_ok <= 1'b0;
      cyc(3);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      undervolt_ok <= 1'b1;
      wt(3, 5);
      chk(general_reset_q, 1, 0);
      cyc(20);
      chk(drive_en_q, 0, 0);
      ev(0);
      wt(2, 5);
      chk(soft_start_q, 1, 0);
      wt(6, 200);
      chk(c, 80, 25);
      chk(drive_en_q, 1, 0);
    end
  endtask
  task results;
    begin
      $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  initial begin
    // fault timer settings: plain, shorted pin, open pin, short circuit
    for (i = 0; i < 4; i = i + 1) begin
      timer_pin_shorted <= (i == 1);
      timer_pin_open <= (i == 2);
      short_circuit_feedback_level <= (i == 3);
      start;
      e = 20 * ((i == 1) ? `PWMFPS_FAULT_SHORTED_MS : (i == 2) ? `PWMFPS_FAULT_OPEN_MS :
        (i == 3) ? 10 : 40);
      @(posedge clk_sys);
      peak_limit_hit <= 1'b1;
      overload_feedback_level <= 1'b1;
      cyc(e / 2);
      chk(error_flag_q, 1, 0);
      chk(freq_mode_q, 1, 0);
      @(posedge clk_sys);
      peak_limit_hit <= 1'b0;
      cyc(3 + rnd(0) % 8);
      @(posedge clk_sys);
      peak_limit_hit <= 1'b1;
      wt(1, e + 60);
      chk(c, e, 30);
      cyc(2);
      chk(drive_en_q, 0, 0);
      peak_limit_hit <= 1'b0;
      overload_feedback_level <= 1'b0;
      short_circuit_feedback_level <= 1'b0;
      n = 0;
      for (k = 0; k < 2 && n == 0; k = k + 1) begin
        cyc(2 + rnd(0) % 8);
        ev(1);
        ev(0);
        wt(2, 6);
        if (soft_start_q === 1'b1) n = k + 1;
      end
      chk(n, 2, 0);
      chk(lo_drive_en_q, i != 3, 0);
    end
    // latch input, brown-out, release
    start;
    wt(4, 2000);
    @(posedge clk_sys);
    latch_input_high <= 1'b1;
    wt(0, 8000);
    chk(c, 6152, 330);
    chk(drive_en_q, 0, 0);
    @(posedge clk_sys);
    latch_input_high <= 1'b0;
    undervolt_ok <= 1'b0;
    cyc(5);
    @(posedge clk_sys);
    undervolt_ok <= 1'b1;
    cyc(5);
    ev(0);
    cyc(5);
    chk(latched_q, 1, 0);
    chk(drive_en_q, 0, 0);
    @(posedge clk_sys);
    latch_hold_current <= 1'b0;
    wt(5, 10);
    chk(latched_q, 0, 0);
    latch_hold_current <= 1'b1;
    // rail overvoltage persistence
    start;
    @(posedge clk_sys);
    rail_overvoltage_level <= 1'b1;
    cyc(1990);
    rail_overvoltage_level <= 1'b0;
    cyc(5);
    chk(latched_q, 0, 0);
    rail_overvoltage_level <= 1'b1;
    wt(0, 2100);
    chk(c, 2002, 4);
    rail_overvoltage_level <= 1'b0;
    cyc(3);
    latch_hold_current <= 1'b0;
    cyc(5);
    latch_hold_current <= 1'b1;
    // oscillator modes from nominal down to skip
    start;
    for (k = 0; k < 5; k = k + 1) begin
      @(posedge clk_sys);
      foldback_feedback_level <= (k < 1);
      fold_end_feedback_level <= (k < 2);
      freeze_feedback_level <= (k < 3);
      skip_feedback_level <= (k < 4);
      cyc(4000);
      chk(freq_mode_q, (k == 0) ? 0 : (k < 3) ? 2 : k, 0);
      chk(setpoint_freeze_q, k > 2, 0);
      chk(drive_en_q, k != 4, 0);
      if (k == 0 || k == 2) begin
        wt(4, 5000);
        cyc(1);
        wt(4, 5000);
        chk(c + 1, (k == 0) ? 1538 : 3846, (k == 0) ? 80 : 200);
      end
    end
    results;
  end
endmodule // tb_pwm_fault_protection_sequencer
bind pwmfps_top pwmfps_checker i_chk (.clk_sys, .rst_n, .latch_input_high,
  .rail_overvoltage_level, .latch_hold_current, .undervolt_ok, .peak_limit_hit,
  .drive_en_q, .latched_q, .error_flag_q, .soft_start_q, .general_reset_q,
  .setpoint_freeze_q, .freq_mode_q, .osc_tick_q);
